// ===== hw/asp_pkg.sv
// Purpose: constants for the converter serial port and conversion sequencer
// Assumes: 10 MHz system clock; host serial clock sampled as a plain input
// Notes:   command byte layout: [7] wen_n, [6] rnw, [5:4] reg sel, [3:2] cont read (11 on, 10 off), [1:0] spare
`default_nettype none
package asp_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned SETTLE_US     = 1000;                 // power-up settle, 1 ms
  localparam int unsigned SETTLE_CYC    = (SETTLE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned RATE_MHZ_X    = 16600;                // output rate in mHz, 16.6 Hz
  localparam int unsigned PERIOD_CYC    = int'((64'(CLK_HZ) * 1000) / RATE_MHZ_X);
  localparam int unsigned ONES_RESET    = 32;                   // ones on din for port reset
  localparam int unsigned CMD_BITS      = 8;
  // command byte fields
  localparam int unsigned CMD_RNW_POS   = 6;
  localparam int unsigned CMD_RS_HI     = 5;
  localparam int unsigned CMD_RS_LO     = 4;
  localparam logic [7:0]  CMD_CREAD_ON  = 8'h3C;                // 001111xx
  localparam logic [7:0]  CMD_CREAD_OFF = 8'h38;                // 001110xx
  localparam logic [7:0]  CMD_CREAD_MSK = 8'hFC;
  // register selects
  localparam logic [1:0]  RS_COMM       = 2'h0;
  localparam logic [1:0]  RS_MODE       = 2'h1;
  localparam logic [1:0]  RS_DATA       = 2'h3;
  // mode and status registers
  localparam int unsigned MODE_MD_HI    = 7;
  localparam int unsigned MODE_MD_LO    = 6;
  localparam logic [7:0]  MODE_RESET    = 8'h02;
  localparam logic [1:0]  MD_CONT       = 2'h0;
  localparam logic [1:0]  MD_SINGLE     = 2'h2;
  localparam logic [1:0]  MD_PDOWN      = 2'h3;
  localparam int unsigned STAT_RDY_POS  = 7;
  localparam logic [7:0]  STAT_RESET    = 8'h88;
  typedef enum logic [1:0] {ASP_CMD, ASP_WR, ASP_RD, ASP_CREAD} asp_port_e;
  typedef enum logic [1:0] {ASP_IDLE, ASP_SETTLE, ASP_CONV} asp_conv_e;
endpackage
`default_nettype wire

// ===== hw/asp_top.sv
// Purpose: serial host port and conversion sequencing of a sigma-delta converter
// Assumes: host serial clock idles high, data sampled on rising, driven on falling
// Notes:   the converter core supplies a sample word; this block times and delivers it
`default_nettype none
// Contract
// - first byte after reset is command
// - command picks read/write and target register
// - dout/ready low when new word arrives
// - dout/ready high after data read completes
// - ready high before data register update
// - all bits move on host serial clock
// - repeat reads allowed except continuous read
// - three-wire use, status ready flag polled
// - msb appears on chip select assertion
// - 32 ones on din reset port
// - that reset restores all registers
// - single conversion: settle, convert, ready, power-down
// - single mode: ready high until next conversion
// - continuous conversion default, flags ready
// - conversion discarded while data register read
// - 16.6 Hz output, two-period settling
// - 001111xx enters continuous read
// - unread word replaced by next conversion
// - 001110xx leaves continuous read
// - mode code 00 cont,10 single,11 down
// - data register read-only, latest result
module asp_top
  import asp_pkg::*;
#(
  parameter int unsigned DATA_W     = 24,
  parameter int unsigned SETTLE_CNT = SETTLE_CYC,
  parameter int unsigned PERIOD_CNT = PERIOD_CYC
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  input  wire logic              i_cs_n,
  input  wire logic              i_sclk,
  input  wire logic              i_din,
  input  wire logic [DATA_W-1:0] i_sample,
  output logic                   o_dout_rdy_n,
  output logic                   o_dout_oe,
  output logic                   o_powered,
  output logic [1:0]             o_mode_select
);
  if (DATA_W != 16 && DATA_W != 24) begin : g_bad_width
    $error("DATA_W must be 16 or 24");
  end
  if (SETTLE_CNT < 1 || PERIOD_CNT < 2) begin : g_bad_timing
    $error("timing counts too small");
  end

  // two-flop synchronisers; first stage read only by second
  logic [2:0] cs_s1_reg, cs_s2_reg;
  logic       cs_d_reg, sclk_d_reg;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_s1_reg <= 3'h7;
      cs_s2_reg <= 3'h7;
    end else begin
      cs_s1_reg <= {i_cs_n, i_sclk, i_din};
      cs_s2_reg <= cs_s1_reg;
    end
  end
  wire cs_n = cs_s2_reg[2];
  wire sclk = cs_s2_reg[1];
  wire din  = cs_s2_reg[0];
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_d_reg   <= 1'b1;
      sclk_d_reg <= 1'b1;
    end else begin
      cs_d_reg   <= cs_n;
      sclk_d_reg <= sclk;
    end
  end
  // transfers move only on host clock edges while selected
  wire sclk_rise = !cs_n && sclk && !sclk_d_reg;
  wire sclk_fall = !cs_n && !sclk && sclk_d_reg;
  wire cs_fall   = !cs_n && cs_d_reg;

  // port state
  asp_port_e  port_reg;
  logic [7:0] in_sr_reg;
  logic [4:0] bit_cnt_reg;
  logic [5:0] ones_reg;
  logic [1:0] rsel_reg;
  logic [7:0] mode_reg;
  logic [7:0] stat_reg;
  logic [DATA_W-1:0] data_reg;
  logic [DATA_W-1:0] out_sr_reg;
  logic [4:0] out_len_reg;
  logic       rdy_n_reg;
  logic       rd_active_reg;

  wire [7:0] in_byte   = {in_sr_reg[6:0], din};
  wire       ones_trip = sclk_rise && din && (ones_reg == 6'(ONES_RESET - 1));
  wire       last_in   = bit_cnt_reg == 5'(CMD_BITS - 1);
  wire       cmd_rnw   = in_byte[CMD_RNW_POS];
  wire [1:0] cmd_rs    = in_byte[CMD_RS_HI:CMD_RS_LO];
  wire       creading  = port_reg == ASP_CREAD;
  wire       is_cr_on  = (in_byte & CMD_CREAD_MSK) == CMD_CREAD_ON;
  wire       is_cr_off = (in_byte & CMD_CREAD_MSK) == CMD_CREAD_OFF;
  wire [1:0] md        = mode_reg[MODE_MD_HI:MODE_MD_LO];

  function automatic logic [4:0] width_of(input logic [1:0] rs);
    width_of = (rs == RS_DATA) ? 5'(DATA_W - 1) : 5'(CMD_BITS - 1);
  endfunction
  function automatic logic [DATA_W-1:0] word_of(input logic [1:0] rs, input logic [7:0] st,
                                                input logic [7:0] mo, input logic [DATA_W-1:0] dr);
    case (rs)
      RS_COMM: word_of = {st, {(DATA_W-8){1'b0}}};
      RS_MODE: word_of = {mo, {(DATA_W-8){1'b0}}};
      RS_DATA: word_of = dr;
      default: word_of = '0;
    endcase
  endfunction

  // conversion sequencer
  asp_conv_e  conv_reg;
  logic [31:0] tmr_reg;
  logic        done_pulse;
  wire         tmr_zero = tmr_reg == 32'h0;
  assign done_pulse = conv_reg == ASP_CONV && tmr_zero;
  // result settles over two periods, then each period after in continuous mode
  wire [31:0] two_per = 32'(2 * PERIOD_CNT - 1);
  wire [31:0] one_per = 32'(PERIOD_CNT - 1);
  wire        md_write = port_reg == ASP_WR && sclk_rise && last_in && rsel_reg == RS_MODE;
  wire [1:0]  new_md   = in_byte[MODE_MD_HI:MODE_MD_LO];

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      conv_reg  <= ASP_CONV;
      // first result after power-on needs the full two-period settling
      tmr_reg   <= 32'(2 * PERIOD_CNT - 1);
    end else if (ones_trip) begin
      conv_reg  <= ASP_CONV;
      tmr_reg   <= two_per;
    end else if (md_write) begin
      case (new_md)
        MD_SINGLE: begin conv_reg <= ASP_SETTLE; tmr_reg <= 32'(SETTLE_CNT - 1); end
        MD_CONT:   begin conv_reg <= ASP_CONV;   tmr_reg <= two_per; end
        default:   begin conv_reg <= ASP_IDLE;   tmr_reg <= 32'h0; end
      endcase
    end else begin
      case (conv_reg)
        ASP_SETTLE: if (tmr_zero) begin conv_reg <= ASP_CONV; tmr_reg <= two_per; end
          else tmr_reg <= tmr_reg - 32'h1;
        ASP_CONV: if (tmr_zero) begin
            if (md == MD_SINGLE) conv_reg <= ASP_IDLE;
            else tmr_reg <= one_per;
          end else tmr_reg <= tmr_reg - 32'h1;
        default: tmr_reg <= 32'h0;
      endcase
    end
  end

  // ready rises one cycle before the data register changes
  logic upd_pend_reg;
  wire  accept = done_pulse && !(rd_active_reg && rsel_reg == RS_DATA && !creading);
  // only a stream reload owns the shifter and counter; other updates drop no host bit
  wire  reload = upd_pend_reg && creading;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      port_reg      <= ASP_CMD;
      in_sr_reg     <= 8'h0;
      bit_cnt_reg   <= 5'h0;
      ones_reg      <= 6'h0;
      rsel_reg      <= RS_COMM;
      mode_reg      <= MODE_RESET;
      stat_reg      <= STAT_RESET;
      data_reg      <= '0;
      out_sr_reg    <= '0;
      out_len_reg   <= 5'h0;
      rdy_n_reg     <= 1'b1;
      rd_active_reg <= 1'b0;
      upd_pend_reg  <= 1'b0;
    end else if (ones_trip) begin
      port_reg      <= ASP_CMD;
      in_sr_reg     <= 8'h0;
      bit_cnt_reg   <= 5'h0;
      ones_reg      <= 6'h0;
      rsel_reg      <= RS_COMM;
      mode_reg      <= MODE_RESET;
      stat_reg      <= STAT_RESET;
      data_reg      <= '0;
      out_sr_reg    <= '0;
      out_len_reg   <= 5'h0;
      rdy_n_reg     <= 1'b1;
      rd_active_reg <= 1'b0;
      upd_pend_reg  <= 1'b0;
    end else begin
      if (sclk_rise) ones_reg <= din ? ones_reg + 6'h1 : 6'h0;
      if (accept) begin
        rdy_n_reg    <= 1'b1;
        upd_pend_reg <= 1'b1;
      end else if (upd_pend_reg) begin
        upd_pend_reg <= 1'b0;
        data_reg     <= i_sample;
        stat_reg[STAT_RDY_POS] <= 1'b0;
        rdy_n_reg    <= 1'b0;
        if (creading) begin
          out_sr_reg    <= i_sample;
          out_len_reg   <= 5'(DATA_W - 1);
          bit_cnt_reg   <= 5'h0;
          rd_active_reg <= 1'b1;
        end
      end
      // msb presented on select fall, later bits on falling host edges
      if (cs_fall && rd_active_reg)
        out_sr_reg <= out_sr_reg;
      else if (sclk_fall && rd_active_reg && bit_cnt_reg != 5'h0 && !reload)
        out_sr_reg <= {out_sr_reg[DATA_W-2:0], 1'b0};
      if (sclk_rise && !reload) begin
        in_sr_reg   <= in_byte;
        bit_cnt_reg <= bit_cnt_reg + 5'h1;
        case (port_reg)
          ASP_CMD: if (last_in) begin
              bit_cnt_reg <= 5'h0;
              rsel_reg    <= cmd_rs;
              if (is_cr_on) begin
                port_reg <= ASP_CREAD;
                rsel_reg <= RS_DATA;
              end else if (cmd_rnw) begin
                port_reg      <= ASP_RD;
                rd_active_reg <= 1'b1;
                out_sr_reg    <= word_of(cmd_rs, stat_reg, mode_reg, data_reg);
                out_len_reg   <= width_of(cmd_rs);
              end else if (cmd_rs != RS_COMM && cmd_rs != RS_DATA) port_reg <= ASP_WR;
            end
          ASP_WR: if (last_in) begin
              bit_cnt_reg <= 5'h0;
              port_reg    <= ASP_CMD;
              if (rsel_reg == RS_MODE) mode_reg <= in_byte;
            end
          ASP_RD, ASP_CREAD: begin
              if (port_reg == ASP_CREAD && last_in && !rdy_n_reg && is_cr_off) begin
                port_reg      <= ASP_CMD;
                rd_active_reg <= 1'b0;
                bit_cnt_reg   <= 5'h0;
              end else if (rd_active_reg && bit_cnt_reg == out_len_reg) begin
                rd_active_reg <= 1'b0;
                bit_cnt_reg   <= 5'h0;
                if (port_reg == ASP_RD) port_reg <= ASP_CMD;
                if (rsel_reg == RS_DATA) begin
                  rdy_n_reg <= 1'b1;
                  stat_reg[STAT_RDY_POS] <= 1'b1;
                end
              end else if (!rd_active_reg && port_reg == ASP_CREAD && last_in)
                bit_cnt_reg <= 5'h0;
            end
          default: port_reg <= ASP_CMD;
        endcase
      end
    end
  end

  // line shows data during a read, ready otherwise, only while selected
  logic dout_reg, oe_reg, pwr_reg;
  logic [1:0] md_out_reg;
  // in continuous read the line shows ready until the host starts clocking the word
  wire  show_data = rd_active_reg && !(creading && bit_cnt_reg == 5'h0 && sclk_d_reg);
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      dout_reg   <= 1'b1;
      oe_reg     <= 1'b0;
      pwr_reg    <= 1'b1;
      md_out_reg <= MD_CONT;
    end else begin
      dout_reg   <= show_data ? out_sr_reg[DATA_W-1] : rdy_n_reg;
      oe_reg     <= !cs_n;
      pwr_reg    <= conv_reg != ASP_IDLE;
      md_out_reg <= md;
    end
  end
  assign o_dout_rdy_n  = dout_reg;
  assign o_dout_oe     = oe_reg;
  assign o_powered     = pwr_reg;
  assign o_mode_select = md_out_reg;

  a_ready_before_upd: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    upd_pend_reg |-> rdy_n_reg) else $error("ready low during data update");
  a_ready_after_upd: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $fell(upd_pend_reg) && !$past(ones_trip) |-> !rdy_n_reg)
    else $error("ready not low after update");
  a_ones_reset_port: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ones_trip |=> port_reg == ASP_CMD && mode_reg == MODE_RESET) else $error("ones reset missed");
  a_single_powerdn: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    done_pulse && md == MD_SINGLE && !md_write && !ones_trip |=> conv_reg == ASP_IDLE)
    else $error("single conversion did not power down");
  a_discard_on_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    done_pulse && !accept |=> !upd_pend_reg) else $error("result kept during data read");
  a_cread_reload: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    upd_pend_reg && creading && !ones_trip |=> rd_active_reg && bit_cnt_reg == 5'h0)
    else $error("continuous read not reloaded");
  a_ready_held_idle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    conv_reg == ASP_IDLE && rdy_n_reg && !upd_pend_reg |=> rdy_n_reg)
    else $error("ready fell with converter idle");
  a_ready_after_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    sclk_rise && !ones_trip && !reload && rd_active_reg && rsel_reg == RS_DATA
      && bit_cnt_reg == out_len_reg |=> rdy_n_reg) else $error("ready not high after read");
endmodule
`default_nettype wire

// ===== testbench/asp_host.sv
// Purpose: host serial port model for the converter port
// Assumes: 8 reference clocks per serial bit (800 ns)
// Notes:   sclk toggles only inside transfers and idles high
`default_nettype none
module asp_host (
  input  wire logic i_ref_clk,
  input  wire logic i_dout_rdy_n,
  output var logic  o_cs_n,
  output var logic  o_sclk,
  output var logic  o_din
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_din  = 1'b0;
  end
  task automatic set_cs(input logic v);
    @(negedge i_ref_clk);
    o_cs_n = v;
  endtask
  // drive on sclk fall, sample late in the high phase so the bit has settled
  task automatic shift(input logic [31:0] v, input int n, output logic [31:0] q);
    q = '0;
    o_cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge i_ref_clk);
      o_sclk = 1'b0;
      o_din  = v[i];
      repeat (4) @(negedge i_ref_clk);
      o_sclk = 1'b1;
      repeat (3) @(negedge i_ref_clk);
      q[i] = i_dout_rdy_n;
    end
    @(negedge i_ref_clk);
    o_din = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== testbench/asp_top_tb.sv
// Purpose: self-checking bench for the converter serial port
// Assumes: short settle and period counts; chip select held low
// Notes:   conversion waits are bounded by one to three output periods, plus the settle count on the first wait and where a settle comes first
`default_nettype none
module asp_top_tb
  import asp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned DW  = 24;
  localparam int unsigned ST  = 50;
  localparam int unsigned PER = 700;
  typedef struct packed {logic [1:0] md; logic pwr;} asp_row_s;
  asp_row_s        rows [3] = '{'{MD_CONT, 1'b1}, '{MD_PDOWN, 1'b0}, '{MD_CONT, 1'b1}};
  logic            i_ref_clk;
  logic            i_rst;
  logic            cs_n;
  logic            sclk;
  logic            din;
  logic [DW-1:0]   i_sample;
  logic            dout_rdy_n;
  logic            dout_oe;
  logic            powered;
  logic [1:0]      mode_sel;
  logic [31:0]     rd;
  int              n_mismatch;
  int              tests_run;
  int              cnt;
  int              t;

  always #50 i_ref_clk = ~i_ref_clk;

  asp_top #(.DATA_W(DW), .SETTLE_CNT(ST), .PERIOD_CNT(PER)) asp_top_inst (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din),
    .i_sample(i_sample), .o_dout_rdy_n(dout_rdy_n), .o_dout_oe(dout_oe),
    .o_powered(powered), .o_mode_select(mode_sel));
  asp_host asp_host_inst (.i_ref_clk(i_ref_clk), .i_dout_rdy_n(dout_rdy_n),
    .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_rdy(input logic lvl, input int lim);
    cnt = 0;
    while (dout_rdy_n !== lvl && cnt < lim) begin
      @(negedge i_ref_clk);
      cnt++;
    end
    if (cnt >= lim) begin
      n_mismatch++;
      $display("MISMATCH t=%0t ready wait ran out", $time);
      test_done();
    end
  endtask
  task automatic cmd_rw(input logic [7:0] c, input logic [31:0] w, input int n);
    asp_host_inst.shift({24'h0, c}, 8, rd);
    if (n > 0)
      asp_host_inst.shift(w, n, rd);
  endtask

  initial begin
    i_ref_clk = 1'b0;
    i_rst = 1'b1;
    i_sample = 24'h123456;
    n_mismatch = 0;
    tests_run = 0;
    repeat (20) @(negedge i_ref_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    chk(dout_rdy_n, 1, "ready idle");
    chk(mode_sel, MD_CONT, "mode default");
    chk(dout_oe, 0, "oe with cs high");
    cmd_rw(8'h40, 0, 8);
    chk(rd, STAT_RESET, "status reset");
    chk(dout_oe, 1, "oe with cs low");
    foreach (rows[k]) begin
      cmd_rw(8'h10, {24'h0, rows[k].md, MODE_RESET[5:0]}, 8);
      repeat (8) @(negedge i_ref_clk);
      chk(mode_sel, rows[k].md, "mode bits");
      chk(powered, rows[k].pwr, "power");
      cmd_rw(8'h50, 0, 8);
      chk(rd, {24'h0, rows[k].md, MODE_RESET[5:0]}, "mode readback");
    end
    i_sample = 24'hA5C3F1;
    wait_rdy(1'b0, 3 * PER + ST);
    i_sample = 24'h5A3C0F;
    wait_rdy(1'b1, PER + 20);
    t = cnt;
    wait_rdy(1'b0, 40);
    chk((t + cnt > PER - 8) && (t + cnt < PER + 8), 1, "output period");
    cmd_rw(8'h70, 0, DW);
    chk(rd, 24'h5A3C0F, "data word");
    repeat (4) @(negedge i_ref_clk);
    chk(dout_rdy_n, 1, "ready after read");
    cmd_rw(8'h70, 0, DW);
    chk(rd, 24'h5A3C0F, "repeat read");
    wait_rdy(1'b0, PER);
    i_sample = 24'hC3C3C3;
    // the next conversion lands in the middle of this read
    repeat (PER - 120) @(negedge i_ref_clk);
    cmd_rw(8'h70, 0, DW);
    chk(rd, 24'h5A3C0F, "read across update");
    cmd_rw(8'h70, 0, DW);
    chk(rd, 24'h5A3C0F, "result discarded");
    wait_rdy(1'b0, 2 * PER);
    cmd_rw(CMD_CREAD_ON, 0, 0);
    i_sample = 24'h0F0F0F;
    wait_rdy(1'b1, PER);
    wait_rdy(1'b0, 40);
    asp_host_inst.shift(0, DW, rd);
    chk(rd, 24'h0F0F0F, "stream word");
    repeat (4) @(negedge i_ref_clk);
    chk(dout_rdy_n, 1, "ready after stream word");
    i_sample = 24'h3C5AA5;
    wait_rdy(1'b0, PER);
    i_sample = 24'h96E187;
    asp_host_inst.shift(0, 8, rd);
    repeat (PER) @(negedge i_ref_clk);
    asp_host_inst.shift(0, DW, rd);
    chk(rd, 24'h96E187, "partial word replaced");
    wait_rdy(1'b0, PER);
    cmd_rw(CMD_CREAD_OFF, 0, 0);
    cmd_rw(8'h70, 0, DW);
    chk(rd, 24'h96E187, "read after exit");
    cmd_rw(8'h10, {24'h0, MD_PDOWN, MODE_RESET[5:0]}, 8);
    i_sample = 24'h7E8118;
    cmd_rw(8'h10, {24'h0, MD_SINGLE, MODE_RESET[5:0]}, 8);
    repeat (8) @(negedge i_ref_clk);
    chk(powered, 1, "single powers up");
    wait_rdy(1'b0, ST + 3 * PER);
    t = cnt + 8;
    chk((t > ST + 2 * PER - 20) && (t < ST + 2 * PER + 20), 1, "single time");
    repeat (8) @(negedge i_ref_clk);
    chk(powered, 0, "back to power-down");
    cmd_rw(8'h40, 0, 8);
    chk(rd[STAT_RDY_POS], 0, "status ready flag");
    cmd_rw(8'h70, 0, DW);
    chk(rd, 24'h7E8118, "single result");
    repeat (4) @(negedge i_ref_clk);
    cnt = 0;
    repeat (3 * PER) begin
      @(negedge i_ref_clk);
      if (dout_rdy_n !== 1'b1)
        cnt++;
    end
    chk(cnt, 0, "ready stays high");
    cmd_rw(8'h70, 0, DW);
    chk(rd, 24'h7E8118, "single reread");
    asp_host_inst.shift(32'hFFFFFFFF, 32, rd);
    repeat (8) @(negedge i_ref_clk);
    chk(mode_sel, MD_CONT, "mode after port reset");
    chk(powered, 1, "power after port reset");
    cmd_rw(8'h50, 0, 8);
    chk(rd, MODE_RESET, "mode reg after port reset");
    asp_host_inst.set_cs(1'b1);
    repeat (6) @(negedge i_ref_clk);
    chk(dout_oe, 0, "line released");
    test_done();
  end
endmodule
`default_nettype wire
